/* File: dect_top.sv */
// Display engine top control bank: gates, resets, dividers and mixer routing.
//
// Design decision made here: register access over APB.
`timescale 1ns/100ps
module dect_top
(
  // Clock and reset.
  input  wire logic                               sys_clk,
  input  wire logic                               sys_rst,
  // APB slave.
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [7:0]                         paddr,
  input  wire logic [31:0]                        pwdata,
  output logic      [31:0]                        prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  // Per-unit clock enables and resets, index 0 main, 1 aux, 2 write-back.
  output logic      [dect_pkg::UNIT_COUNT-1:0]    proc_clk_en,
  output logic      [dect_pkg::UNIT_COUNT-1:0]    bus_clk_pass,
  output logic      [dect_pkg::UNIT_COUNT-1:0]    unit_rst_n,
  // Mixer pixel inputs.
  input  wire logic [dect_pkg::PIXEL_WIDTH-1:0]   main_mixer_pixel,
  input  wire logic                               main_mixer_valid,
  input  wire logic [dect_pkg::PIXEL_WIDTH-1:0]   aux_mixer_pixel,
  input  wire logic                               aux_mixer_valid,
  // Timing controller pixel outputs.
  output logic      [dect_pkg::PIXEL_WIDTH-1:0]   timing_controller_a_pixel,
  output logic                                    timing_controller_a_valid,
  output logic      [dect_pkg::PIXEL_WIDTH-1:0]   timing_controller_b_pixel,
  output logic                                    timing_controller_b_valid
);

  typedef logic [dect_pkg::DIV_WIDTH-1:0] dect_div_t;

  typedef struct packed
  {
    logic [dect_pkg::UNIT_COUNT-1:0]  proc_gates;
    logic [dect_pkg::UNIT_COUNT-1:0]  bus_gates;
    logic [dect_pkg::UNIT_COUNT-1:0]  resets;
    dect_div_t [dect_pkg::UNIT_COUNT-1:0] divs;
    logic                             swap;
    dect_div_t [dect_pkg::UNIT_COUNT-1:0] div_cnt;
    logic [dect_pkg::UNIT_COUNT-1:0]  clk_en;
    logic [31:0]                      rdata;
    logic [dect_pkg::PIXEL_WIDTH-1:0] pix_a;
    logic                             val_a;
    logic [dect_pkg::PIXEL_WIDTH-1:0] pix_b;
    logic                             val_b;
  } dect_state_t;

  dect_state_t state_ff;
  dect_state_t nxt_state;

  // Address decode shared by read and write paths; returns one-hot register hit.
  function automatic logic [4:0] dect_decode(input logic [7:0] addr);
    logic [4:0] hit;
    hit = 5'h0;
    if (addr == dect_pkg::ADDR_PROC_GATES)
    begin
      hit = 5'h01;
    end
    else if (addr == dect_pkg::ADDR_BUS_GATES)
    begin
      hit = 5'h02;
    end
    else if (addr == dect_pkg::ADDR_UNIT_RESETS)
    begin
      hit = 5'h04;
    end
    else if (addr == dect_pkg::ADDR_DIVIDERS)
    begin
      hit = 5'h08;
    end
    else if (addr == dect_pkg::ADDR_ROUTING)
    begin
      hit = 5'h10;
    end
    return hit;
  endfunction : dect_decode

  // Places the unit bits of a gate or reset register in their bus word.
  function automatic logic [31:0] dect_unit_word
  (
    input logic [dect_pkg::UNIT_COUNT-1:0] bits
  );
    logic [31:0] word;
    word = 32'h0000_0000;
    word[dect_pkg::UNIT_COUNT-1:0] = bits;
    return word & dect_pkg::GATE_MASK;
  endfunction : dect_unit_word

  // Packs the per-unit divide settings into their bus word.
  function automatic logic [31:0] dect_div_word
  (
    input dect_div_t [dect_pkg::UNIT_COUNT-1:0] divs
  );
    logic [31:0] word;
    word = 32'h0000_0000;
    for (int u = 0; u < dect_pkg::UNIT_COUNT; u++)
    begin
      word[u*dect_pkg::DIV_WIDTH +: dect_pkg::DIV_WIDTH] = divs[u];
    end
    return word & dect_pkg::DIV_MASK;
  endfunction : dect_div_word

  // Places the routing bit in its bus word.
  function automatic logic [31:0] dect_route_word
  (
    input logic swap
  );
    logic [31:0] word;
    word = 32'h0000_0000;
    word[dect_pkg::ROUTE_SWAP_BIT] = swap;
    return word & dect_pkg::ROUTE_MASK;
  endfunction : dect_route_word

  // Mask of the stored fields of the register hit, so that upper write bits are dropped.
  function automatic logic [31:0] dect_write_mask
  (
    input logic [4:0] sel
  );
    logic [31:0] mask;
    mask = 32'h0000_0000;
    if (sel[0])
    begin
      mask = dect_pkg::GATE_MASK;
    end
    else if (sel[1])
    begin
      mask = dect_pkg::GATE_MASK;
    end
    else if (sel[2])
    begin
      mask = dect_pkg::GATE_MASK;
    end
    else if (sel[3])
    begin
      mask = dect_pkg::DIV_MASK;
    end
    else if (sel[4])
    begin
      mask = dect_pkg::ROUTE_MASK;
    end
    return mask;
  endfunction : dect_write_mask

  // Reset image of the state: every register field takes the common reset value.
  function automatic dect_state_t dect_reset_state();
    dect_state_t image;
    logic [31:0] rst_word;
    image = '0;
    rst_word = dect_pkg::REG_RESET;
    image.proc_gates = rst_word[dect_pkg::UNIT_COUNT-1:0];
    image.bus_gates = rst_word[dect_pkg::UNIT_COUNT-1:0];
    image.resets = rst_word[dect_pkg::UNIT_COUNT-1:0];
    for (int u = 0; u < dect_pkg::UNIT_COUNT; u++)
    begin
      image.divs[u] = rst_word[u*dect_pkg::DIV_WIDTH +: dect_pkg::DIV_WIDTH];
    end
    image.swap = rst_word[dect_pkg::ROUTE_SWAP_BIT];
    return image;
  endfunction : dect_reset_state

  logic [4:0]                      hit;
  logic [31:0]                     wr_word;
  logic [dect_pkg::UNIT_COUNT-1:0] unit_live;
  logic                            wr_en;
  logic                            rd_en;

  always_comb
  begin
    hit = dect_decode(paddr);
    wr_en = psel && penable && pwrite;
    rd_en = psel && !penable && !pwrite;
    wr_word = pwdata & dect_write_mask(hit);
    unit_live = state_ff.proc_gates & state_ff.resets;
    nxt_state = state_ff;
    // Writes take effect at the access edge; upper bits are masked off.
    if (wr_en)
    begin
      if (hit[0])
      begin
        nxt_state.proc_gates = wr_word[dect_pkg::UNIT_COUNT-1:0];
      end
      else if (hit[1])
      begin
        nxt_state.bus_gates = wr_word[dect_pkg::UNIT_COUNT-1:0];
      end
      else if (hit[2])
      begin
        nxt_state.resets = wr_word[dect_pkg::UNIT_COUNT-1:0];
      end
      else if (hit[3])
      begin
        for (int u = 0; u < dect_pkg::UNIT_COUNT; u++)
        begin
          nxt_state.divs[u] = wr_word[u*dect_pkg::DIV_WIDTH +: dect_pkg::DIV_WIDTH];
        end
      end
      else if (hit[4])
      begin
        nxt_state.swap = wr_word[dect_pkg::ROUTE_SWAP_BIT];
      end
    end
    // Read data is captured in the setup cycle so it stands in the access cycle.
    if (rd_en)
    begin
      if (hit[0])
      begin
        nxt_state.rdata = dect_unit_word(state_ff.proc_gates);
      end
      else if (hit[1])
      begin
        nxt_state.rdata = dect_unit_word(state_ff.bus_gates);
      end
      else if (hit[2])
      begin
        nxt_state.rdata = dect_unit_word(state_ff.resets);
      end
      else if (hit[3])
      begin
        nxt_state.rdata = dect_div_word(state_ff.divs);
      end
      else if (hit[4])
      begin
        nxt_state.rdata = dect_route_word(state_ff.swap);
      end
      else
      begin
        nxt_state.rdata = 32'h0000_0000;
      end
    end
    // Per-unit divider: a one-cycle enable every (setting + 1) cycles while gated on and out of unit reset.
    for (int i = 0; i < dect_pkg::UNIT_COUNT; i++)
    begin
      if (!unit_live[i])
      begin
        nxt_state.div_cnt[i] = 4'h0;
        nxt_state.clk_en[i] = 1'b0;
      end
      else if (state_ff.div_cnt[i] >= state_ff.divs[i])
      begin
        nxt_state.div_cnt[i] = 4'h0;
        nxt_state.clk_en[i] = 1'b1;
      end
      else
      begin
        nxt_state.div_cnt[i] = 4'(state_ff.div_cnt[i] + 4'h1);
        nxt_state.clk_en[i] = 1'b0;
      end
    end
    // Mixer to timing controller routing, registered.
    if (state_ff.swap)
    begin
      nxt_state.pix_a = aux_mixer_pixel;
      nxt_state.val_a = aux_mixer_valid;
      nxt_state.pix_b = main_mixer_pixel;
      nxt_state.val_b = main_mixer_valid;
    end
    else
    begin
      nxt_state.pix_a = main_mixer_pixel;
      nxt_state.val_a = main_mixer_valid;
      nxt_state.pix_b = aux_mixer_pixel;
      nxt_state.val_b = aux_mixer_valid;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state_ff <= dect_reset_state();
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign prdata = state_ff.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && (hit == 5'h0);
  // Per-unit control outputs.
  for (genvar u = 0; u < dect_pkg::UNIT_COUNT; u++)
  begin : g_unit
    assign proc_clk_en[u]  = state_ff.clk_en[u];
    assign bus_clk_pass[u] = state_ff.bus_gates[u];
    assign unit_rst_n[u]   = state_ff.resets[u];
  end
  assign timing_controller_a_pixel = state_ff.pix_a;
  assign timing_controller_a_valid = state_ff.val_a;
  assign timing_controller_b_pixel = state_ff.pix_b;
  assign timing_controller_b_valid = state_ff.val_b;

endmodule : dect_top

/* File: dect_pkg.sv */
// Package with register map, field layout and width constants of the display top control.
package dect_pkg;
  localparam logic [7:0]  ADDR_PROC_GATES   = 8'h00;
  localparam logic [7:0]  ADDR_BUS_GATES    = 8'h04;
  localparam logic [7:0]  ADDR_UNIT_RESETS  = 8'h08;
  localparam logic [7:0]  ADDR_DIVIDERS     = 8'h0C;
  localparam logic [7:0]  ADDR_ROUTING      = 8'h10;
  localparam int          UNIT_COUNT        = 3;
  localparam int          MAIN_BIT          = 0;
  localparam int          AUX_BIT           = 1;
  localparam int          WB_BIT            = 2;
  localparam int          DIV_WIDTH         = 4;
  localparam int          ROUTE_SWAP_BIT    = 0;
  localparam logic [31:0] GATE_MASK         = 32'h0000_0007;
  localparam logic [31:0] DIV_MASK          = 32'h0000_0FFF;
  localparam logic [31:0] ROUTE_MASK        = 32'h0000_0001;
  localparam logic [31:0] REG_RESET         = 32'h0000_0000;
  localparam int          PIXEL_WIDTH       = 24;
endpackage : dect_pkg

/* File: dect_monitor.sv */
// Port checker of the display top control bank.
`timescale 1ns/100ps
module dect_monitor
(
  // Clock and reset.
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  // Register bus.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // Unit controls and pixel paths.
  input wire logic [2:0]  proc_clk_en,
  input wire logic [2:0]  bus_clk_pass,
  input wire logic [2:0]  unit_rst_n,
  input wire logic [23:0] main_mixer_pixel,
  input wire logic [23:0] aux_mixer_pixel,
  input wire logic [23:0] timing_controller_a_pixel,
  input wire logic [23:0] timing_controller_b_pixel
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  logic        acc, rd, unm;
  logic [47:0] tco;
  assign acc = psel && penable;
  assign rd = psel && !penable && !pwrite;
  assign unm = !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10});
  assign tco = {timing_controller_a_pixel, timing_controller_b_pixel};
  AST_SLVERR: assert property (acc && unm |-> pslverr)
    else $error("no error on unmapped access");
  AST_READY: assert property (acc |-> pready)
    else $error("access not answered");
  AST_UNMAPPED_READ: assert property (rd && unm |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  AST_BUS_GATE: assert property (acc && pwrite && paddr == 8'h04
    |=> bus_clk_pass == $past(pwdata[2:0])) else $error("bus gate mismatch");
  AST_UNIT_RST: assert property (acc && pwrite && paddr == 8'h08
    |=> unit_rst_n == $past(pwdata[2:0])) else $error("unit reset mismatch");
  AST_RESET_VAL: assert property ($past(sys_rst) |->
    {proc_clk_en, bus_clk_pass, unit_rst_n} == 9'h0) else $error("outputs not cleared");
  AST_HELD: assert property ((proc_clk_en & ~unit_rst_n & ~$past(unit_rst_n)) == 3'h0)
    else $error("enable pulse in reset");
  AST_READ_RST: assert property (rd && paddr == 8'h08
    |=> prdata == {29'h0, unit_rst_n}) else $error("reset readback mismatch");
  AST_ROUTE: assert property (!$past(sys_rst) |-> tco == {$past(main_mixer_pixel),
    $past(aux_mixer_pixel)} || tco == {$past(aux_mixer_pixel), $past(main_mixer_pixel)})
    else $error("pixel path mismatch");
  cover property (acc && unm);
  cover property (acc && pwrite && paddr == 8'h0C);
  cover property (proc_clk_en[1]);
endmodule : dect_monitor
bind dect_top dect_monitor i_mon
(
  .sys_clk, .sys_rst, .psel, .penable, .pwrite, .pready, .pslverr, .paddr, .pwdata, .prdata,
  .proc_clk_en, .bus_clk_pass, .unit_rst_n, .main_mixer_pixel, .aux_mixer_pixel,
  .timing_controller_a_pixel, .timing_controller_b_pixel
);

/* File: dect_tcon_model.sv */
// Timing controller model that keeps the last valid pixel it received.
`timescale 1ns/100ps
module dect_tcon_model
(
  // Clock.
  input wire logic        sys_clk,
  // Pixel stream from the control bank.
  input wire logic        valid,
  input wire logic [23:0] pixel,
  // Last pixel accepted.
  output logic     [23:0] seen
);
  always_ff @(posedge sys_clk)
  begin
    if (valid)
    begin
      seen <= pixel;
    end
  end
endmodule : dect_tcon_model

/* File: dect_top_tb.sv */
// Self-checking bench for the display top control bank.
`timescale 1ns/100ps
module dect_top_tb;
  logic sys_clk = 1'h0, sys_rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic main_mixer_valid = 1'h0, aux_mixer_valid = 1'h0, pready, pslverr, er;
  logic timing_controller_a_valid, timing_controller_b_valid;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [2:0] proc_clk_en, bus_clk_pass, unit_rst_n;
  logic [23:0] main_mixer_pixel = 24'h0, aux_mixer_pixel = 24'h0, sa, sb;
  logic [23:0] timing_controller_a_pixel, timing_controller_b_pixel;
  logic [31:0] msk [6] = '{32'h7, 32'h7, 32'h7, 32'hFFF, 32'h1, 32'h0};
  int failures = 0, checks_done = 0;
  dect_top i_dut (.sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .proc_clk_en, .bus_clk_pass, .unit_rst_n, .main_mixer_pixel,
    .main_mixer_valid, .aux_mixer_pixel, .aux_mixer_valid, .timing_controller_a_pixel,
    .timing_controller_a_valid, .timing_controller_b_pixel, .timing_controller_b_valid);
  dect_tcon_model i_ta (.sys_clk, .valid(timing_controller_a_valid),
    .pixel(timing_controller_a_pixel), .seen(sa));
  dect_tcon_model i_tb (.sys_clk, .valid(timing_controller_b_valid),
    .pixel(timing_controller_b_pixel), .seen(sb));
  initial
    forever #2.5 sys_clk = ~sys_clk;
  task chk(input string n, input logic [31:0] e, s);
    checks_done++;
    if (s !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    @(posedge sys_clk);
    while (pready !== 1'h1)
      @(posedge sys_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge sys_clk);
  endtask : apb
  task t_map;
    for (int i = 0; i < 5; i++)
    begin
      apb(1'h0, 8'(4 * i), 32'h0);
      chk("reset value", 32'h0, rd);
    end
    for (int i = 0; i < 6; i++)
    begin
      apb(1'h1, 8'(4 * i), 32'hFFFF_FFFF);
      apb(1'h0, 8'(4 * i), 32'h0);
      chk("readback", msk[i], rd);
      chk("slave error", i == 5, er);
    end
    chk("bus gates", 32'h7, bus_clk_pass);
  endtask : t_map
  task t_div;
    int n [3];
    apb(1'h1, 8'h0C, 32'hF20);
    for (int g = 0; g < 2; g++)
    begin
      apb(1'h1, 8'h00, g ? 32'h5 : 32'h7);
      repeat (20) @(posedge sys_clk);
      n = '{0, 0, 0};
      repeat (48)
      begin
        @(negedge sys_clk);
        for (int u = 0; u < 3; u++)
          n[u] += proc_clk_en[u];
      end
      @(posedge sys_clk);
      chk("main pulses", 48, n[0]);
      chk("aux pulses", g ? 0 : 16, n[1]);
      chk("wb pulses", 3, n[2]);
    end
  endtask : t_div
  task t_route;
    for (int s = 0; s < 2; s++)
    begin
      apb(1'h1, 8'h10, 32'(s));
      main_mixer_pixel <= 24'hA5A5A5;
      aux_mixer_pixel <= 24'h5A5A5A;
      main_mixer_valid <= 1'h1;
      aux_mixer_valid <= 1'h1;
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("controller a", s ? 24'h5A5A5A : 24'hA5A5A5, sa);
      chk("controller b", s ? 24'hA5A5A5 : 24'h5A5A5A, sb);
      @(posedge sys_clk);
      aux_mixer_valid <= 1'h0;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("controller a valid", s ? 0 : 1, timing_controller_a_valid);
      chk("controller b valid", s ? 1 : 0, timing_controller_b_valid);
      @(posedge sys_clk);
    end
  endtask : t_route
  task t_reset;
    apb(1'h1, 8'h04, 32'h6);
    sys_rst <= 1'h1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'h0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk("proc enables", 32'h0, proc_clk_en);
    chk("bus gates", 32'h0, bus_clk_pass);
    chk("unit resets", 32'h0, unit_rst_n);
    @(posedge sys_clk);
    for (int i = 0; i < 5; i++)
    begin
      apb(1'h0, 8'(4 * i), 32'h0);
      chk("reset value", 32'h0, rd);
    end
  endtask : t_reset
  task end_sim;
    if (failures == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  initial
  begin
    #20000;
    failures++;
    end_sim();
  end
  initial
  begin
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'h0;
    @(posedge sys_clk);
    t_map();
    t_div();
    t_route();
    t_reset();
    end_sim();
  end
endmodule : dect_top_tb
